// file: hdl/flash_cmd.sv
// Purpose: instruction handling of a page-erasable serial flash behind a four-wire link
// Assumes: link clock idles while deselected; host waits for busy to clear
// Notes: link logic runs on sclk_i, array update and timer on mclk_i
//
// What this block does
// - identification read shifts out twenty bytes
// - length byte 10h, blank factory bytes 00h
// - identification read ignored while cycle busy
// - deselect stops output and abandons identification
// - deselect returns to standby awaiting selection
// - status read always accepted, byte repeats
// - status bit0 busy, bit1 latch, rest zero
// - busy high only during internal cycle
// - latch clear refuses every write
// - normal read: three address bytes, upper ignored
// - fast read inserts one dummy byte
// - read address increments and wraps to zero
// - reads end on deselect, rejected while busy
// - unlock instruction sets latch for rewrite
// - rewrite replaces page, untouched bytes kept
// - data past page end wraps within page
// - last 256 bytes kept, others unchanged
// - rewrite executes only on byte boundary
// - deselect starts timed cycle, latch cleared
// - protected or busy rewrite not executed
// - protect pin low locks first 256 pages
// - opcodes 9Fh 05h 03h 0Bh 0Ah 06h
// - msb first, sampled from first rising edge
`timescale 1ns/1ns
`default_nettype none
`include "flash_cmd_params.svh"

module flash_cmd #(
	parameter int REWRITE_CYCLES = `REWRITE_CYCLES, // must exceed 256
	parameter logic [7:0] MFR_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] TYPE_CODE = 8'hc3, // arbitrary value
	parameter logic [7:0] CAP_CODE = 8'h07, // arbitrary value
	parameter logic [127:0] CFD_BYTES = 128'h0 // blank factory bytes
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	input wire logic wp_n_i,
	output logic so_o,
	output logic so_oe_o
);

	localparam int TW = $clog2(REWRITE_CYCLES + 1);
	localparam logic [TW-1:0] TMR_LAST = TW'(REWRITE_CYCLES - 1);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] mem_q [0:131071]; // array, written by system side only
	logic [7:0] pbuf_q [0:255]; // page data latched from the link
	logic [255:0] mask_q; // which page bytes arrived

	// ----------------------------------------
	// link side: frame tracking on rising sclk
	// ----------------------------------------
	flash_cmd_pkg::frame_s frame_q, frame_d, base; // frame summary
	flash_cmd_pkg::cmd_e cmd_q, cmd_d; // decoded instruction
	logic fresh_q; // set while deselected, cleared by first rising edge
	logic [16:0] rd_addr_q, rd_addr_d; // read pointer
	logic [7:0] col_q, col_d; // page column for incoming data
	logic [6:0] dsh_q, dsh_d; // partial input byte
	logic [7:0] in_byte; // completed input byte
	logic byte_done; // eighth bit of a byte this edge
	logic pb_we; // store a data byte
	logic pb_clr; // forget old page data
	logic busy_s, wel_s; // flags seen on the link clock

	// rising edge while deselected marks standby; cs high forces fresh
	// standby until selected
	always_ff @(posedge sclk_i or posedge cs_n_i)
	begin
		if (cs_n_i)
			fresh_q <= 1'b1;
		else
			fresh_q <= 1'b0;
	end

	// opcode decode; array accesses are refused while a cycle runs
	// reads rejected while busy
	function automatic flash_cmd_pkg::cmd_e decode(input logic [7:0] op, input logic busy);
		unique case (op)
			`OP_IDENT_READ: decode = busy ? flash_cmd_pkg::no_cmd : flash_cmd_pkg::ident_read_cmd;
			`OP_STATUS_READ: decode = flash_cmd_pkg::status_read_cmd;
			`OP_NORMAL_READ: decode = busy ? flash_cmd_pkg::no_cmd : flash_cmd_pkg::normal_read_cmd;
			`OP_FAST_READ: decode = busy ? flash_cmd_pkg::no_cmd : flash_cmd_pkg::fast_read_cmd;
			`OP_PAGE_REWRITE: decode = busy ? flash_cmd_pkg::no_cmd : flash_cmd_pkg::page_rewrite_cmd;
			`OP_WRITE_UNLOCK: decode = flash_cmd_pkg::write_unlock_cmd;
			default: decode = flash_cmd_pkg::no_cmd;
		endcase
	endfunction

	// next values of the link-side frame state
	always_comb
	begin
		// first rising edge after select restarts the count
		base = fresh_q ? '0 : frame_q;
		frame_d = base;
		cmd_d = fresh_q ? flash_cmd_pkg::no_cmd : cmd_q;
		rd_addr_d = rd_addr_q;
		col_d = col_q;
		pb_we = 1'b0;
		pb_clr = 1'b0;
		in_byte = {(fresh_q ? 7'h00 : dsh_q), sdi_i};
		dsh_d = in_byte[6:0];
		byte_done = (base.nbits == 3'h7);
		frame_d.nbits = base.nbits + 3'h1;
		if (byte_done)
		begin
			// saturate so long reads never look like a header again
			if (base.nbytes != 9'h1ff)
				frame_d.nbytes = base.nbytes + 9'h001;
			if (base.nbytes == 9'h000)
			begin
				frame_d.opcode = in_byte;
				cmd_d = decode(in_byte, busy_s);
				pb_clr = (cmd_d == flash_cmd_pkg::page_rewrite_cmd);
			end
			else if (base.nbytes < 9'h004)
			begin
				// only the low seventeen address bits survive the shift
				frame_d.addr = {base.addr[8:0], in_byte};
				rd_addr_d = {base.addr[8:0], in_byte};
				col_d = in_byte;
			end
			else
			begin
				// advance after each output byte, wraps naturally
				if ((cmd_q == flash_cmd_pkg::normal_read_cmd && base.nbytes >= `HDR_NORMAL_BYTES)
					|| (cmd_q == flash_cmd_pkg::fast_read_cmd && base.nbytes >= `HDR_FAST_BYTES))
					rd_addr_d = rd_addr_q + 17'h00001;
				if (cmd_q == flash_cmd_pkg::page_rewrite_cmd)
				begin
					pb_we = 1'b1;
					col_d = col_q + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge sclk_i)
	begin
		frame_q <= frame_d;
		cmd_q <= cmd_d;
		rd_addr_q <= rd_addr_d;
		col_q <= col_d;
		dsh_q <= dsh_d;
	end

	// page buffer; only an accepted rewrite touches it, so a status poll
	// during the copy cannot disturb data the system side is reading
	// later bytes overwrite earlier ones at the same column
	always_ff @(posedge sclk_i)
	begin
		if (pb_clr)
			mask_q <= '0;
		else if (pb_we)
			mask_q[col_q] <= 1'b1;
		if (pb_we)
			pbuf_q[col_q] <= in_byte;
	end

	// ----------------------------------------
	// link side: output on falling sclk
	// ----------------------------------------
	logic [7:0] out_byte; // byte being shifted out
	logic [4:0] id_idx; // identification byte index
	logic drive; // output phase of the frame
	logic so_q, so_d, oe_q, oe_d;

	// select the byte for the current output position
	always_comb
	begin
		id_idx = 5'(frame_q.nbytes - 9'h001);
		out_byte = 8'h00;
		drive = 1'b0;
		unique case (cmd_q)
			flash_cmd_pkg::ident_read_cmd:
			begin
				// maker, two device bytes, length, factory bytes
				drive = 1'b1;
				if (frame_q.nbytes > 9'h014)
					out_byte = 8'h00;
				else if (id_idx == 5'h00)
					out_byte = MFR_CODE;
				else if (id_idx == 5'h01)
					out_byte = TYPE_CODE;
				else if (id_idx == 5'h02)
					out_byte = CAP_CODE;
				else if (id_idx == 5'h03)
					out_byte = `IDENT_LEN_VALUE;
				else
					out_byte = CFD_BYTES[8'(`IDENT_LAST_INDEX - id_idx) * 8 +: 8];
			end
			flash_cmd_pkg::status_read_cmd:
			begin
				// same byte for as long as clocks arrive
				drive = 1'b1;
				out_byte[`STAT_BUSY_BIT] = busy_s;
				out_byte[`STAT_LATCH_BIT] = wel_s;
			end
			flash_cmd_pkg::normal_read_cmd:
			begin
				drive = (frame_q.nbytes >= `HDR_NORMAL_BYTES);
				out_byte = mem_q[rd_addr_q];
			end
			flash_cmd_pkg::fast_read_cmd:
			begin
				// dummy byte delays output by one byte
				drive = (frame_q.nbytes >= `HDR_FAST_BYTES);
				out_byte = mem_q[rd_addr_q];
			end
			default:
				drive = 1'b0;
		endcase
		oe_d = drive && !fresh_q;
		so_d = oe_d ? out_byte[3'h7 - frame_q.nbits] : 1'b0;
	end

	// falling edge shifts; deselect releases the line at once
	// stop driving on deselect
	always_ff @(negedge sclk_i or posedge cs_n_i)
	begin
		if (cs_n_i)
		begin
			so_q <= 1'b0;
			oe_q <= 1'b0;
		end
		else
		begin
			so_q <= so_d;
			oe_q <= oe_d;
		end
	end

	assign so_o = so_q;
	assign so_oe_o = oe_q;

	// ----------------------------------------
	// crossings
	// ----------------------------------------
	logic cs_s, wp_s; // pins seen on the system clock
	logic busy_q, busy_d, wel_q, wel_d;

	sync_two #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
		.clk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.en_i(clk_en_i),
		.d_i({cs_n_i, wp_n_i}),
		.q_o({cs_s, wp_s})
	);

	// the link clock only runs in frames, so these flags settle within
	// the first opcode bits, well before they are decoded
	sync_two #(.W(2), .RST_VAL(2'h0)) u_flag_sync (
		.clk_i(sclk_i),
		.rst_b_i(1'b1),
		.en_i(1'b1),
		.d_i({busy_q, wel_q}),
		.q_o({busy_s, wel_s})
	);

	// ----------------------------------------
	// system side: execution and timed rewrite cycle
	// ----------------------------------------
	logic cs_prev_q, cs_prev_d; // last synchronised select level
	logic cs_rise; // deselect seen this cycle
	logic whole; // frame ended on a byte boundary
	logic prot; // page lies in the locked region
	logic unlock_ok, write_ok;
	logic [8:0] page_q, page_d; // page under rewrite
	logic [8:0] idx_q, idx_d; // copy position, 256 when done
	logic [TW-1:0] tmr_q, tmr_d; // cycle timer
	logic copy_we; // copy one page byte into the array

	// frame_q, cmd_q and the page buffer are quiet while deselected, so
	// they are read here only after the select level has crossed
	always_comb
	begin
		cs_rise = cs_s && !cs_prev_q;
		whole = (frame_q.nbits == 3'h0);
		// lower half locked while the pin is low
		prot = !wp_s && !frame_q.addr[16];
		// unlock sets the latch when idle
		unlock_ok = cs_rise && whole && !busy_q && frame_q.nbytes == 9'h001
			&& cmd_q == flash_cmd_pkg::write_unlock_cmd;
		// latch needed; not protected, not busy
		write_ok = cs_rise && whole && wel_q && !busy_q && !prot
			&& cmd_q == flash_cmd_pkg::page_rewrite_cmd
			&& frame_q.nbytes >= `REWRITE_MIN_BYTES;
		cs_prev_d = cs_s;
		busy_d = busy_q;
		wel_d = wel_q;
		page_d = page_q;
		idx_d = idx_q;
		tmr_d = tmr_q;
		copy_we = 1'b0;
		if (unlock_ok)
			wel_d = 1'b1;
		if (write_ok)
		begin
			busy_d = 1'b1;
			wel_d = 1'b0;
			page_d = frame_q.addr[16:8];
			idx_d = 9'h000;
			tmr_d = '0;
		end
		else if (busy_q)
		begin
			// copy only bytes that arrived, others keep old value
			if (!idx_q[8])
			begin
				copy_we = mask_q[idx_q[7:0]];
				idx_d = idx_q + 9'h001;
			end
			// busy ends when the timer expires
			tmr_d = tmr_q + 1'b1;
			if (tmr_q == TMR_LAST)
				busy_d = 1'b0;
		end
		if (!clk_en_i)
		begin
			cs_prev_d = cs_prev_q;
			busy_d = busy_q;
			wel_d = wel_q;
			page_d = page_q;
			idx_d = idx_q;
			tmr_d = tmr_q;
			copy_we = 1'b0;
		end
		if (!rst_b_i)
		begin
			cs_prev_d = 1'b1;
			busy_d = 1'b0;
			wel_d = 1'b0;
			page_d = 9'h000;
			idx_d = 9'h100;
			tmr_d = '0;
			copy_we = 1'b0;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		cs_prev_q <= cs_prev_d;
		busy_q <= busy_d;
		wel_q <= wel_d;
		page_q <= page_d;
		idx_q <= idx_d;
		tmr_q <= tmr_d;
	end

	always_ff @(posedge mclk_i)
	begin
		if (copy_we)
			mem_q[{page_q, idx_q[7:0]}] <= pbuf_q[idx_q[7:0]];
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_cycle_start: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		write_ok && clk_en_i |=> busy_q && !wel_q)
		else $error("rewrite did not raise busy and clear latch");
	chk_latch_refuse: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		cs_rise && !wel_q && !busy_q && !unlock_ok |=> !busy_q)
		else $error("rewrite ran without write latch");
	chk_protect_page: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		cs_rise && prot && !busy_q |=> !busy_q)
		else $error("protected page was rewritten");
	chk_busy_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		$rose(busy_q) |-> busy_q [*8])
		else $error("busy dropped early");
	chk_byte_edge: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		cs_rise && frame_q.nbits != 3'h0 && !busy_q |=> !busy_q)
		else $error("partial byte frame executed");
	chk_idle_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		cs_n_i |-> !so_oe_o)
		else $error("output driven while deselected");
	chk_status_zero: assert property (@(posedge sclk_i) disable iff (cs_n_i)
		cmd_q == flash_cmd_pkg::status_read_cmd |-> out_byte[7:2] == 6'h00)
		else $error("status upper bits not zero");
	chk_ident_len: assert property (@(posedge sclk_i) disable iff (cs_n_i)
		cmd_q == flash_cmd_pkg::ident_read_cmd && frame_q.nbytes == 9'h004
		|-> out_byte == `IDENT_LEN_VALUE)
		else $error("length byte wrong");
	chk_read_reject: assert property (@(posedge sclk_i) disable iff (cs_n_i)
		!fresh_q && byte_done && frame_q.nbytes == 9'h000 && busy_s
		&& in_byte == `OP_NORMAL_READ |=> cmd_q == flash_cmd_pkg::no_cmd)
		else $error("read accepted while busy");
	chk_addr_wrap: assert property (@(posedge sclk_i) disable iff (cs_n_i)
		!fresh_q && byte_done && cmd_q == flash_cmd_pkg::normal_read_cmd
		&& frame_q.nbytes >= `HDR_NORMAL_BYTES && rd_addr_q == 17'h1ffff
		|=> rd_addr_q == 17'h00000)
		else $error("read address did not wrap");

	cov_rewrite: cover property (@(posedge mclk_i) disable iff (!rst_b_i) write_ok);
	cov_fast: cover property (@(posedge sclk_i) cmd_q == flash_cmd_pkg::fast_read_cmd && oe_d);
	cov_ident: cover property (@(posedge sclk_i) cmd_q == flash_cmd_pkg::ident_read_cmd
		&& frame_q.nbytes == 9'h014);

endmodule // flash_cmd

`default_nettype wire

// file: hdl/flash_cmd_params.svh
// Purpose: opcodes, status bit positions, identification layout and timing counts
// Assumes: included by bare name from the flash command block
// Notes: definitions only
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

// ----------------------------------------
// instruction codes
// ----------------------------------------
`define OP_IDENT_READ 8'h9f
`define OP_STATUS_READ 8'h05
`define OP_NORMAL_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_PAGE_REWRITE 8'h0a
`define OP_WRITE_UNLOCK 8'h06

// ----------------------------------------
// status byte layout
// ----------------------------------------
`define STAT_BUSY_BIT 0
`define STAT_LATCH_BIT 1

// ----------------------------------------
// identification block and frame layout
// ----------------------------------------
`define IDENT_LEN_VALUE 8'h10
`define IDENT_LAST_INDEX 5'h13
`define HDR_NORMAL_BYTES 9'h004
`define HDR_FAST_BYTES 9'h005
`define REWRITE_MIN_BYTES 9'h005

// ----------------------------------------
// timing: rewrite cycle time in microseconds at the system clock rate
// ----------------------------------------
`define REWRITE_TIME_US 11000
`define MCLK_MHZ 25
`define REWRITE_CYCLES (`REWRITE_TIME_US * `MCLK_MHZ)

`endif

// file: hdl/flash_cmd_pkg.sv
// Purpose: shared types of the flash command block
// Assumes: nothing
// Notes: constants live in flash_cmd_params.svh
package flash_cmd_pkg;

	// decoded instruction of the current frame
	typedef enum logic [2:0] {
		no_cmd,
		ident_read_cmd,
		status_read_cmd,
		normal_read_cmd,
		fast_read_cmd,
		page_rewrite_cmd,
		write_unlock_cmd
	} cmd_e;

	// running summary of one frame, read by the system side after deselect
	typedef struct packed {
		logic [7:0] opcode;
		logic [8:0] nbytes;
		logic [2:0] nbits;
		logic [16:0] addr;
	} frame_s;

endpackage

// file: hdl/sync_two.sv
// Purpose: two flip-flop level synchroniser
// Assumes: d_i is a level from another clock domain or a pin
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module sync_two #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic en_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_q, meta_d; // metastable stage
	logic [W-1:0] hold_q, hold_d; // settled stage

	// next values: advance only while enabled
	always_comb
	begin
		meta_d = en_i ? d_i : meta_q;
		hold_d = en_i ? meta_q : hold_q;
		if (!rst_b_i)
		begin
			meta_d = RST_VAL;
			hold_d = RST_VAL;
		end
	end

	always_ff @(posedge clk_i)
	begin
		meta_q <= meta_d;
		hold_q <= hold_d;
	end

	assign q_o = hold_q;

endmodule // sync_two

`default_nettype wire

// file: testbench/spi_host_model.sv
// Purpose: host side of the four-wire link, shifting whole frames
// Assumes: mode 0, clock idles low and stands still between frames
// Notes: half period hp is 3 ns by default and may be stretched by the bench
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
	input wire logic mclk_i,
	input wire logic so_i,
	input wire logic so_oe_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic sdi_o
);
	logic [7:0] tx [0:299]; // bytes to send
	logic [7:0] rx [0:299]; // bytes seen on so_i
	logic oe_seen; // device drove during the frame
	int hp = 3; // half period in ns

	// one deselect edge after power-up puts the link logic in standby;
	// without it the frame state would stay unknown through the first frame
	initial
	begin
		cs_n_o = 1'b0;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		oe_seen = 1'b0;
		#1;
		cs_n_o = 1'b1;
	end

	// ----------------------------------------
	// one frame of nbits clocks
	// ----------------------------------------
	// select low throughout, msb first, exact bit count
	task automatic xfer(input int nbits);
		int k;
		@(posedge mclk_i);
		oe_seen = 1'b0;
		cs_n_o <= 1'b0;
		for (k = 0; k < nbits; k++)
		begin
			sdi_o <= tx[k / 8][7 - k % 8];
			#(hp);
			sclk_o <= 1'b1;
			// output launched on the previous falling edge is settled here
			rx[k / 8][7 - k % 8] = so_i;
			oe_seen = oe_seen | so_oe_i;
			#(hp);
			sclk_o <= 1'b0;
		end
		#(hp);
		cs_n_o <= 1'b1;
		// released line must not keep looking valid
		sdi_o <= ~sdi_o;
		// deselect gap well over four system cycles
		repeat (6) @(posedge mclk_i);
	endtask
endmodule // spi_host_model

`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: self-checking bench of the flash command block
// Assumes: rewrite cycle shortened to 300 system cycles
// Notes: array content is unknown until written, so only written bytes are read
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
	$display("Error at %0t got %h expected %h", $time, (a), (e)); end end

module tb_top;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic wp_n_i = 1'b1;
	logic clk_en = 1'b1; // system-side clock enable
	logic sclk, cs_n, sdi, so, so_oe; // link wires
	logic [7:0] s; // last status byte
	int mismatches = 0;
	int checks = 0;

	always #20 mclk_i = ~mclk_i;

	flash_cmd #(
		.REWRITE_CYCLES(300)
	) i_dut (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.clk_en_i(clk_en),
		.sclk_i(sclk),
		.cs_n_i(cs_n),
		.sdi_i(sdi),
		.wp_n_i(wp_n_i),
		.so_o(so),
		.so_oe_o(so_oe)
	);

	spi_host_model i_host (
		.mclk_i(mclk_i),
		.so_i(so),
		.so_oe_i(so_oe),
		.cs_n_o(cs_n),
		.sclk_o(sclk),
		.sdi_o(sdi)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic cmd(input logic [7:0] op, input logic [23:0] a);
		i_host.tx[0] = op;
		i_host.tx[1] = a[23:16];
		i_host.tx[2] = a[15:8];
		i_host.tx[3] = a[7:0];
	endtask

	// second repeat of the byte, since the flags reach the link two edges late
	task automatic status();
		i_host.tx[0] = 8'h05;
		i_host.xfer(24);
		s = i_host.rx[2];
	endtask

	task automatic wait_idle();
		int n;
		s = 8'h01;
		for (n = 0; n < 200 && s[0] !== 1'b0; n++)
			status();
		`CHK(s[0], 1'b0)
	endtask

	task automatic rewrite(input logic [23:0] a, input int nbytes);
		i_host.tx[0] = 8'h06;
		i_host.xfer(8);
		cmd(8'h0a, a);
		i_host.xfer(32 + 8 * nbytes);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_ident();
		int k;
		logic [7:0] e;
		i_host.tx[0] = 8'h9f;
		i_host.xfer(20);
		`CHK(i_host.rx[1][7:4], 4'h5)
		`CHK(so_oe, 1'b0)
		i_host.xfer(8 * 22);
		for (k = 1; k < 22; k++)
		begin
			e = (k == 1) ? 8'h5a : (k == 2) ? 8'hc3 : (k == 3) ? 8'h07 : (k == 4) ? 8'h10 : 8'h00;
			`CHK(i_host.rx[k], e)
		end
		$display("test ident done");
	endtask

	task automatic t_status();
		int k;
		i_host.hp = 20;
		i_host.tx[0] = 8'h05;
		i_host.xfer(32);
		i_host.hp = 3;
		for (k = 1; k < 4; k++)
			`CHK(i_host.rx[k], 8'h00)
		i_host.tx[0] = 8'h06;
		i_host.xfer(8);
		status();
		`CHK(s, 8'h02)
		$display("test status done");
	endtask

	task automatic t_refuse();
		// besides an executed rewrite, mid-run reset is the only way this block clears a set latch
		@(posedge mclk_i) rst_b_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		status();
		`CHK(s, 8'h00)
		cmd(8'h0a, 24'h010000);
		i_host.xfer(40);
		status();
		`CHK(s[0], 1'b0)
		@(posedge mclk_i) wp_n_i <= 1'b0;
		rewrite(24'h000100, 1);
		status();
		`CHK(s[0], 1'b0)
		@(posedge mclk_i) wp_n_i <= 1'b1;
		// latch set, then a frame cut three bits into a data byte
		i_host.tx[0] = 8'h06;
		i_host.xfer(8);
		cmd(8'h0a, 24'h010000);
		i_host.xfer(43);
		status();
		`CHK(s, 8'h02)
		$display("test refuse done");
	endtask

	task automatic t_write();
		i_host.tx[4] = 8'h11;
		i_host.tx[5] = 8'h22;
		i_host.tx[6] = 8'h33;
		rewrite(24'h0123fe, 3);
		status();
		`CHK(s, 8'h01)
		cmd(8'h03, 24'h0123fe);
		i_host.xfer(48);
		`CHK(i_host.oe_seen, 1'b0)
		i_host.tx[0] = 8'h9f;
		i_host.xfer(16);
		`CHK(i_host.oe_seen, 1'b0)
		wait_idle();
		cmd(8'h03, 24'hff23fe);
		i_host.xfer(48);
		`CHK(i_host.rx[4], 8'h11)
		`CHK(i_host.rx[5], 8'h22)
		cmd(8'h0b, 24'h012300);
		i_host.xfer(48);
		`CHK(i_host.rx[5], 8'h33)
		$display("test write done");
	endtask

	task automatic t_page();
		int k;
		for (k = 0; k < 258; k++)
			i_host.tx[4 + k] = k[7:0] ^ ((k >= 256) ? 8'hff : 8'h00);
		rewrite(24'h000000, 258);
		wait_idle();
		i_host.tx[4] = 8'ha5;
		rewrite(24'h000005, 1);
		// a frozen timer must outlast the nominal cycle length
		clk_en <= 1'b0;
		repeat (400) @(posedge mclk_i);
		status();
		`CHK(s, 8'h01)
		@(posedge mclk_i) clk_en <= 1'b1;
		wait_idle();
		i_host.tx[4] = 8'h3c;
		rewrite(24'h01ffff, 1);
		wait_idle();
		cmd(8'h03, 24'h01ffff);
		i_host.xfer(64);
		`CHK(i_host.rx[4], 8'h3c)
		`CHK(i_host.rx[5], 8'hff)
		`CHK(i_host.rx[6], 8'hfe)
		`CHK(i_host.rx[7], 8'h02)
		cmd(8'h03, 24'h000004);
		i_host.xfer(56);
		`CHK(i_host.rx[4], 8'h04)
		`CHK(i_host.rx[5], 8'ha5)
		`CHK(i_host.rx[6], 8'h06)
		$display("test page done");
	endtask

	// ----------------------------------------
	// verdict, sequence and watchdog
	// ----------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		t_ident();
		t_status();
		t_refuse();
		t_write();
		t_page();
		end_sim();
	end

	// four timed cycles plus frames take far less than this
	initial
	begin
		#500000;
		mismatches++;
		end_sim();
	end
endmodule // tb_top

`default_nettype wire
